// *** hw/urxs_regs.svh ***
// register offsets, field positions, reset values and sizes of the receive status block
`ifndef URXS_REGS_SVH
`define URXS_REGS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define URXS_STA_OFS 8'h00
`define URXS_CTRL_OFS 8'h04
`define URXS_DIV_OFS 8'h08
`define URXS_DATA_OFS 8'h0c
// ****************************************
// status and control fields
// ****************************************
`define URXS_ISEL_HI 7
`define URXS_ISEL_LO 6
`define URXS_ADDRESS_DETECT_ENABLE_BIT 5
`define URXS_IDLE_BIT 4
`define URXS_PARITY_ERROR_FLAG_BIT 3
`define URXS_FRAMING_ERROR_FLAG_BIT 2
`define URXS_OVERRUN_ERROR_FLAG_BIT 1
`define URXS_RXDA_BIT 0
// ****************************************
// mode control fields
// ****************************************
`define URXS_NINE_BIT 0
`define URXS_PEN_BIT 1
`define URXS_PODD_BIT 2
// ****************************************
// reset values, sizes, answers
// ****************************************
`define URXS_ISEL_RST 2'h0
`define URXS_CTRL_RST 3'h0
`define URXS_DIV_RST 16'h043d
`define URXS_FIFO_DEPTH 4
`define URXS_FIFO_WIDTH 11
`define URXS_LVL_3Q 3'h3
`define URXS_LVL_FULL 3'h4
`define URXS_RESP_OKAY 2'h0
`define URXS_RESP_SLVERR 2'h2
`endif

// *** hw/urxs_pkg.sv ***
// types shared by the receive status block
package urxs_pkg;
  typedef enum logic [2:0] {
    URXS_ST_IDLE = 3'b000,
    URXS_ST_START = 3'b001,
    URXS_ST_DATA = 3'b010,
    URXS_ST_PAR = 3'b011,
    URXS_ST_STOP = 3'b100
  } urxs_rx_state_type;
endpackage

// *** hw/urxs_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module urxs_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // clock, reset, enable
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic flush,
  // fill side
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  // honest full and empty straight from the count
  assign in_ready = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign count = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage needs no reset, pointers guard it
  always_ff @(posedge aclk) begin
    if (ce && push && !flush) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and count, flush empties at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (flush) begin
        wp_r <= '0;
        rp_r <= '0;
        cnt_r <= '0;
      end else begin
        if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
        if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
        cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
    end
  end
endmodule

// *** hw/urxs_rx_shift.sv ***
// serial receive shift register with one-character holding stage
`timescale 1ns/1ns
module urxs_rx_shift
  import urxs_pkg::*;
(
  // clock, reset, enable
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic flush,
  // line and modes
  input logic rx_in,
  input logic [15:0] bit_div,
  input logic nine_bit,
  input logic parity_en,
  input logic parity_odd,
  // character out
  output logic out_valid,
  input logic out_ready,
  output logic [8:0] out_data,
  output logic out_parity_error_flag,
  output logic out_framing_error_flag,
  // state
  output logic idle,
  output logic overrun
);
  urxs_rx_state_type st_r;
  logic [15:0] tmr_r;
  logic [3:0] bit_r;
  logic [8:0] shf_r;
  logic par_r;
  logic pe_r;
  logic samp;
  logic done;

  assign samp = (tmr_r == 16'h0000);
  assign done = (st_r == URXS_ST_STOP) && samp;
  assign idle = (st_r == URXS_ST_IDLE);

  // bit timing and framing; sample mid-bit after half-bit start delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= URXS_ST_IDLE;
      tmr_r <= 16'h0000;
      bit_r <= 4'h0;
      shf_r <= 9'h000;
      par_r <= 1'b0;
      pe_r <= 1'b0;
    end else if (ce) begin
      tmr_r <= samp ? bit_div - 16'h0001 : tmr_r - 16'h0001;
      case (st_r)
        URXS_ST_IDLE: begin
          if (!rx_in) begin
            st_r <= URXS_ST_START;
            tmr_r <= {1'b0, bit_div[15:1]};
          end
        end
        URXS_ST_START: begin
          if (samp) begin
            st_r <= rx_in ? URXS_ST_IDLE : URXS_ST_DATA;
            bit_r <= 4'h0;
            par_r <= 1'b0;
            pe_r <= 1'b0;
          end
        end
        URXS_ST_DATA: begin
          if (samp) begin
            shf_r <= {rx_in, shf_r[8:1]};
            par_r <= par_r ^ rx_in;
            bit_r <= bit_r + 4'h1;
            if (bit_r == (nine_bit ? 4'h8 : 4'h7)) begin
              st_r <= (parity_en && !nine_bit) ? URXS_ST_PAR : URXS_ST_STOP;
            end
          end
        end
        URXS_ST_PAR: begin
          if (samp) begin
            pe_r <= par_r ^ rx_in ^ parity_odd;
            st_r <= URXS_ST_STOP;
          end
        end
        URXS_ST_STOP: begin
          if (samp) st_r <= URXS_ST_IDLE;
        end
        default: st_r <= URXS_ST_IDLE;
      endcase
      if (flush) st_r <= URXS_ST_IDLE;
    end
  end

  // holding stage; a finished character meeting a full stage is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data <= 9'h000;
      out_parity_error_flag <= 1'b0;
      out_framing_error_flag <= 1'b0;
      overrun <= 1'b0;
    end else if (ce) begin
      overrun <= 1'b0;
      if (flush) begin
        out_valid <= 1'b0;
      end else if (done && out_valid && !out_ready) begin
        overrun <= 1'b1;
      end else if (done) begin
        out_valid <= 1'b1;
        out_data <= nine_bit ? shf_r : {1'b0, shf_r[8:1]};
        out_parity_error_flag <= pe_r;
        out_framing_error_flag <= !rx_in;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// *** hw/urxs_top.sv ***
// receive status, buffer and interrupt-level logic of a serial port, axi4-lite registers
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "urxs_regs.svh"
module urxs_top
  import urxs_pkg::*;
(
  // clock, reset, enable
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // axi4-lite write
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // axi4-lite read
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  // serial line and event
  input logic rx_in,
  output logic rx_int
);
  // ****************************************
  // declarations
  // ****************************************
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic ar_fire;
  logic [1:0] isel_r;
  logic address_detect_enable_r;
  logic overrun_error_flag_r;
  logic [2:0] ctrl_r;
  logic [15:0] div_r;
  logic overrun_error_flag_clr;
  logic flush;
  logic rx_valid;
  logic rx_ready;
  logic [8:0] rx_data;
  logic rx_parity_error_flag;
  logic rx_framing_error_flag;
  logic rx_idle;
  logic rx_ovr;
  logic discard;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [10:0] fifo_head;
  logic [2:0] fifo_cnt;
  logic push;
  logic [2:0] lvl_after;
  logic [15:0] sta_word;

  // ****************************************
  // receive path
  // ****************************************
  urxs_rx_shift u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .flush(flush),
    .rx_in(rx_in),
    .bit_div(div_r),
    .nine_bit(ctrl_r[`URXS_NINE_BIT]),
    .parity_en(ctrl_r[`URXS_PEN_BIT]),
    .parity_odd(ctrl_r[`URXS_PODD_BIT]),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .out_parity_error_flag(rx_parity_error_flag),
    .out_framing_error_flag(rx_framing_error_flag),
    .idle(rx_idle),
    .overrun(rx_ovr)
  );

  // non-address characters are dropped only in 9-bit mode
  assign discard = address_detect_enable_r && ctrl_r[`URXS_NINE_BIT] && !rx_data[8];
  assign fifo_in_valid = rx_valid && !discard;
  // a full fifo stalls the holding stage, which then overruns
  assign rx_ready = discard || fifo_in_ready;
  assign push = fifo_in_valid && fifo_in_ready;

  urxs_fifo #(
    .WIDTH(`URXS_FIFO_WIDTH),
    .DEPTH(`URXS_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .flush(flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({rx_parity_error_flag, rx_framing_error_flag, rx_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_head),
    .count(fifo_cnt)
  );

  // ****************************************
  // receive interrupt level
  // ****************************************
  assign lvl_after = fifo_cnt + 3'(push) - 3'(fifo_pop);

  // one-cycle event pulse, level chosen by the select field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_int <= 1'b0;
    end else if (ce) begin
      rx_int <= push && (!isel_r[1] ||
        (isel_r == 2'b10 && lvl_after == `URXS_LVL_3Q) ||
        (isel_r == 2'b11 && lvl_after == `URXS_LVL_FULL));
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // ready is gated by the enable so a frozen block never accepts a beat it cannot record
  assign awready = ce && !aw_hold_r;
  assign wready = ce && !w_hold_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid;

  // address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `URXS_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awaddr_r[7:4] == 4'h0) ? `URXS_RESP_OKAY : `URXS_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // software may only clear overrun; the 1 to 0 edge flushes
  assign overrun_error_flag_clr = wr_fire && awaddr_r == `URXS_STA_OFS && wstrb_r[0] && !wdata_r[`URXS_OVERRUN_ERROR_FLAG_BIT];
  assign flush = overrun_error_flag_clr && overrun_error_flag_r && !rx_ovr;

  // writable control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isel_r <= `URXS_ISEL_RST;
      address_detect_enable_r <= 1'b0;
      ctrl_r <= `URXS_CTRL_RST;
      div_r <= `URXS_DIV_RST;
    end else if (ce && wr_fire) begin
      if (awaddr_r == `URXS_STA_OFS && wstrb_r[0]) begin
        isel_r <= wdata_r[`URXS_ISEL_HI:`URXS_ISEL_LO];
        address_detect_enable_r <= wdata_r[`URXS_ADDRESS_DETECT_ENABLE_BIT];
      end
      if (awaddr_r == `URXS_CTRL_OFS && wstrb_r[0]) ctrl_r <= wdata_r[2:0];
      if (awaddr_r == `URXS_DIV_OFS && wstrb_r[0]) div_r[7:0] <= wdata_r[7:0];
      if (awaddr_r == `URXS_DIV_OFS && wstrb_r[1]) div_r[15:8] <= wdata_r[15:8];
    end
  end

  // overrun: a new overflow wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_error_flag_r <= 1'b0;
    end else if (ce) begin
      overrun_error_flag_r <= rx_ovr || (overrun_error_flag_r && !overrun_error_flag_clr);
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign arready = ce && !rvalid;
  assign ar_fire = arvalid && arready;
  // reading the data word removes the top character
  assign fifo_pop = ar_fire && araddr == `URXS_DATA_OFS && fifo_out_valid && !flush;

  // error flags come from the fifo head, so a pop exposes the next one
  assign sta_word = {8'h00, isel_r, address_detect_enable_r,
    rx_idle,
    fifo_out_valid && fifo_head[10],
    fifo_out_valid && fifo_head[9],
    overrun_error_flag_r,
    fifo_out_valid};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `URXS_RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        rvalid <= 1'b1;
        rresp <= `URXS_RESP_OKAY;
        case (araddr)
          `URXS_STA_OFS: rdata <= {16'h0000, sta_word};
          `URXS_CTRL_OFS: rdata <= {29'h0000_0000, ctrl_r};
          `URXS_DIV_OFS: rdata <= {16'h0000, div_r};
          `URXS_DATA_OFS: rdata <= {23'h00_0000, fifo_out_valid ? fifo_head[8:0] : 9'h000};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `URXS_RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_int_full;
    (ce && push && isel_r == 2'b11) |=> (rx_int == ($past(lvl_after) == `URXS_LVL_FULL));
  endproperty
  a_int_full: assert property (p_int_full) else $error("full-level interrupt wrong");

  property p_int_3q;
    (ce && push && isel_r == 2'b10) |=> (rx_int == ($past(lvl_after) == `URXS_LVL_3Q));
  endproperty
  a_int_3q: assert property (p_int_3q) else $error("three-quarter interrupt wrong");

  property p_int_each;
    (ce && push && !isel_r[1]) |=> rx_int;
  endproperty
  a_int_each: assert property (p_int_each) else $error("per-character interrupt missing");

  property p_int_cause;
    (rx_int && $past(ce)) |-> $past(push);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without transfer");

  property p_addr_drop;
    (rx_valid && address_detect_enable_r && ctrl_r[`URXS_NINE_BIT] && !rx_data[8]) |-> !fifo_in_valid;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("data character passed in address mode");

  property p_addr_off8;
    (rx_valid && !ctrl_r[`URXS_NINE_BIT]) |-> fifo_in_valid;
  endproperty
  a_addr_off8: assert property (p_addr_off8) else $error("address detect acted outside 9-bit");

  property p_sta_read;
    (ce && ar_fire && araddr == `URXS_STA_OFS) |=>
      rdata[`URXS_IDLE_BIT] == $past(rx_idle) &&
      rdata[`URXS_PARITY_ERROR_FLAG_BIT] == $past(fifo_out_valid && fifo_head[10]) &&
      rdata[`URXS_FRAMING_ERROR_FLAG_BIT] == $past(fifo_out_valid && fifo_head[9]) &&
      rdata[`URXS_RXDA_BIT] == ($past(fifo_cnt) != 3'h0);
  endproperty
  a_sta_read: assert property (p_sta_read) else $error("status read mismatch");

  property p_ovr_set;
    (ce && rx_ovr) |=> overrun_error_flag_r;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");

  property p_ovr_noself;
    (ce && !overrun_error_flag_r && !rx_ovr) |=> !overrun_error_flag_r;
  endproperty
  a_ovr_noself: assert property (p_ovr_noself) else $error("overrun set without overflow");

  property p_flush;
    (ce && flush) |=> (fifo_cnt == 3'h0 && !rx_valid && rx_idle);
  endproperty
  a_flush: assert property (p_flush) else $error("clear did not empty buffers");

  property p_top_follow;
    (ce && fifo_pop && fifo_cnt == 3'h1 && !push) |=> !sta_word[`URXS_PARITY_ERROR_FLAG_BIT] && !sta_word[`URXS_FRAMING_ERROR_FLAG_BIT];
  endproperty
  a_top_follow: assert property (p_top_follow) else $error("flags kept after last pop");

  c_full_int: cover property (ce && push && isel_r == 2'b11 && lvl_after == `URXS_LVL_FULL);
  c_overrun: cover property (rx_ovr);
  c_flush: cover property (flush);
  c_addr_drop: cover property (rx_valid && discard);
endmodule

// *** bench/urxs_tx_model.sv ***
// serial transmitter model driving the receive line of the status block
`timescale 1ns/1ns
module urxs_tx_model (
  // clock
  input wire logic aclk,
  // serial line, idles high like a pulled-up line
  output logic line
);
  // ****************************************
  // line driver
  // ****************************************
  initial line = 1'b1;

  // holds one level for a whole bit time, changed just after an edge
  task automatic drive(input logic v, input int div);
    @(posedge aclk);
    line <= v;
    repeat (div - 1) @(posedge aclk);
  endtask

  // one frame: start, data lsb first, optional parity, stop, then one idle bit
  // pk 0 none, 1 even, 2 odd; flip spoils the parity, stop low makes a framing fault
  task automatic send(input logic [8:0] d, input int nb, input int pk, input logic flip, input logic stop,
                      input int div);
    logic par;
    par = (pk == 2) ? ~^d[7:0] : ^d[7:0];
    drive(1'b0, div);
    for (int i = 0; i < nb; i++) begin
      drive(d[i], div);
    end
    if (pk != 0) begin
      drive(par ^ flip, div);
    end
    drive(stop, div);
    drive(1'b1, div);
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking testbench of the receive status block
`timescale 1ns/1ns
`include "urxs_regs.svh"
module tb
  import urxs_pkg::*;
;
  // short bit time keeps the run small; expectations do not depend on it
  localparam int DIV = 16;
  localparam int LIMIT = 60000;
  logic aclk, aresetn, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic rx_in, rx_int;
  int errors, samples_checked, cycles, int_count;
  int nb, pk;
  logic [31:0] d;

  urxs_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_in(rx_in), .rx_int(rx_int));
  urxs_tx_model line_model (.aclk(aclk), .line(rx_in));

  // ****************************************
  // clock, pulse counter, timeout
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // counts one-cycle interrupt pulses; scenarios compare differences
  always @(posedge aclk) begin
    if (rx_int === 1'b1) int_count <= int_count + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      results();
    end
  end

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        check("write response", {30'h0, bresp}, {30'h0, er});
        return;
      end
    end
    check("write answered", 32'h0, 32'h1);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    v = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        v = rdata;
        check("read response", {30'h0, rresp}, {30'h0, er});
        return;
      end
    end
    check("read answered", 32'h0, 32'h1);
  endtask

  task automatic sta_chk(input logic [31:0] mask, input logic [31:0] exp, input string name);
    logic [31:0] v;
    axi_read(`URXS_STA_OFS, v, `URXS_RESP_OKAY);
    check(name, v & mask, exp);
  endtask

  task automatic pop_chk(input logic [8:0] exp);
    logic [31:0] v;
    axi_read(`URXS_DATA_OFS, v, `URXS_RESP_OKAY);
    check("data word", v, {23'h0, exp});
  endtask

  // one character on the line; exp is the pulse count, negative skips it
  task automatic tx(input logic [8:0] c, input logic flip, input logic stop, input int exp);
    int base;
    base = int_count;
    line_model.send(c, nb, pk, flip, stop, DIV);
    repeat (4) @(posedge aclk);
    if (exp >= 0) check("interrupt pulses", int_count - base, exp);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    sta_chk(32'hffff_ffff, 32'h0000_0010, "status after reset");
    axi_read(8'h40, d, `URXS_RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    axi_write(8'h40, 32'h0, `URXS_RESP_SLVERR);
    axi_write(`URXS_STA_OFS, 32'h0000_0032, `URXS_RESP_OKAY);
    sta_chk(32'h0000_001f, 32'h0000_0010, "read-only bits after write");
    axi_write(`URXS_DIV_OFS, DIV, `URXS_RESP_OKAY);
  endtask

  // every select code, four characters each, then drained in order
  task automatic t_levels();
    for (int s = 0; s < 4; s++) begin
      axi_write(`URXS_STA_OFS, {24'h0, s[1:0], 6'h02}, `URXS_RESP_OKAY);
      for (int k = 1; k <= 4; k++) begin
        tx(9'(16 * s + k), 1'b0, 1'b1, int'((s < 2) || (s == 2 && k == 3) || (s == 3 && k == 4)));
      end
      sta_chk(32'h1, 32'h1, "data available");
      for (int k = 1; k <= 4; k++) pop_chk(9'(16 * s + k));
      sta_chk(32'h1, 32'h0, "buffer empty");
    end
  endtask

  // six unread characters overflow four entries plus the holding stage
  task automatic t_overrun();
    axi_write(`URXS_STA_OFS, 32'h0000_0002, `URXS_RESP_OKAY);
    for (int k = 0; k < 6; k++) tx(9'(8'h60 + k), 1'b0, 1'b1, (k < 4) ? 1 : -1);
    sta_chk(32'h3, 32'h3, "overrun set");
    axi_write(`URXS_STA_OFS, 32'h0000_0002, `URXS_RESP_OKAY);
    sta_chk(32'h2, 32'h2, "overrun kept by writing one");
    axi_write(`URXS_STA_OFS, 32'h0000_0000, `URXS_RESP_OKAY);
    sta_chk(32'h3, 32'h0, "overrun cleared and buffer emptied");
    pop_chk(9'h000);
    tx(9'h077, 1'b0, 1'b1, 1);
    pop_chk(9'h077);
  endtask

  task automatic t_errors();
    axi_write(`URXS_CTRL_OFS, 32'h2, `URXS_RESP_OKAY);
    pk = 1;
    tx(9'h033, 1'b1, 1'b1, 1);
    tx(9'h044, 1'b0, 1'b0, 1);
    tx(9'h055, 1'b0, 1'b1, 1);
    sta_chk(32'hc, 32'h8, "parity flag on top");
    pop_chk(9'h033);
    sta_chk(32'hc, 32'h4, "framing flag on new top");
    pop_chk(9'h044);
    sta_chk(32'hc, 32'h0, "flags clean on last top");
    pop_chk(9'h055);
    axi_write(`URXS_CTRL_OFS, 32'h6, `URXS_RESP_OKAY);
    pk = 2;
    tx(9'h0c3, 1'b0, 1'b1, 1);
    sta_chk(32'hd, 32'h1, "odd parity accepted");
    pop_chk(9'h0c3);
    pk = 0;
  endtask

  // address detect drops bit8 low only in nine-bit mode
  task automatic t_addr();
    axi_write(`URXS_CTRL_OFS, 32'h1, `URXS_RESP_OKAY);
    axi_write(`URXS_STA_OFS, 32'h0000_0022, `URXS_RESP_OKAY);
    nb = 9;
    tx(9'h055, 1'b0, 1'b1, 0);
    sta_chk(32'h1, 32'h0, "plain data dropped");
    tx(9'h1a7, 1'b0, 1'b1, 1);
    pop_chk(9'h1a7);
    axi_write(`URXS_CTRL_OFS, 32'h0, `URXS_RESP_OKAY);
    nb = 8;
    tx(9'h012, 1'b0, 1'b1, 1);
    pop_chk(9'h012);
  endtask

  task automatic t_idle();
    fork
      tx(9'h0e1, 1'b0, 1'b1, 1);
      begin
        repeat (5 * DIV) @(posedge aclk);
        sta_chk(32'h10, 32'h0, "receiver busy");
      end
    join
    sta_chk(32'h11, 32'h11, "receiver idle again");
    pop_chk(9'h0e1);
  endtask

  // enable low must hold off the read until it returns; a lost request would hang the read
  task automatic t_freeze();
    int t0;
    t0 = cycles;
    ce <= 1'b0;
    fork
      sta_chk(32'h11, 32'h10, "status read across freeze");
      begin
        repeat (10) @(posedge aclk);
        ce <= 1'b1;
      end
    join
    check("read waited for enable", (cycles - t0 > 10) ? 32'h1 : 32'h0, 32'h1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    int_count = 0;
    nb = 8;
    pk = 0;
    ce = 1'b1;
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_levels();
    t_overrun();
    t_errors();
    t_addr();
    t_idle();
    t_freeze();
    results();
  end
endmodule
